// >>> adcbs_cfg.svh
// Chain positions, safe values and timing counts for the converter scan segment
`ifndef ADCBS_CFG_SVH
`define ADCBS_CFG_SVH

// ****************************************
// Chain layout
// ****************************************
`define ADCBS_CHAIN_LEN 198
`define ADCBS_ANALOG_MSB 197
`define ADCBS_ANALOG_LSB 158
`define ADCBS_COMP_POS 193
`define ADCBS_CONV_EN_POS 188
`define ADCBS_DAC_MSB 186
`define ADCBS_DAC_LSB 177
`define ADCBS_HOLD_POS 174
`define ADCBS_MUX_MSB 172
`define ADCBS_MUX_LSB 165
`define ADCBS_COMPARATOR_PRECHARGE_CELL_POS 160
`define ADCBS_PE_BASE 157
`define ADCBS_PA_BASE 23
`define ADCBS_PORT_PINS 8
`define ADCBS_CELLS_PER_PIN 3

// ****************************************
// Safe values outside boundary-scan test
// ****************************************
`define ADCBS_DAC_MID 10'h200
`define ADCBS_MUX_SAFE 8'h01
`define ADCBS_HOLD_SAFE 1'h1
`define ADCBS_COMPARATOR_PRECHARGE_CELL_SAFE 1'h1

// ****************************************
// Timing
// ****************************************
`define ADCBS_CLK_NS 5
`define ADCBS_SETTLE_NS 200
`define ADCBS_CMP_STEPS 10
`define ADCBS_STEP_CYC 4

`endif

// >>> adcbs_pkg.sv
// Types shared by the converter scan segment
package adcbs_pkg;

  // Gray codes along idle -> converting
  typedef enum logic [0:0] {
    ADCBS_IDLE = 1'b0,
    ADCBS_CONV = 1'b1
  } adcbs_conv_state_t;

  typedef enum logic [1:0] {
    ADCBS_CELL_DATA = 2'h0,
    ADCBS_CELL_DIR = 2'h1,
    ADCBS_CELL_PULLUP = 2'h2
  } adcbs_cell_role_t;

endpackage : adcbs_pkg

// >>> adcbs_sync2.sv
// Two-flop synchroniser for pin-side levels
`timescale 1ns/10ps
module adcbs_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : adcbs_sync2

// >>> adcbs_chain.sv
// Converter and comparator boundary-scan segment with pin cells
// Contract
// - Enabling the converter in normal mode runs one ten-step dummy conversion.
// - Chain position 0 is first in from TDI and first out on TDO.
// - Port A cells run in reverse bit order to other ports.
// - Analog cells sit at chain positions 197 down to 158.
// - Each pin has data, direction, pull-up cells in descending positions.
// - Port F pins 4 to 7 have no cells in the chain.
`timescale 1ns/10ps
`include "adcbs_cfg.svh"
module adcbs_chain
  import adcbs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire logic comp_in,
  input wire logic capture_dr_in,
  input wire logic shift_dr_in,
  input wire logic update_dr_in,
  input wire logic extest_in,
  input wire logic func_conv_en_in,
  input wire logic [`ADCBS_CHAIN_LEN-1:0] capture_vec_in,
  output logic tdo_out,
  output logic converter_enable_cell_out,
  output logic [`ADCBS_DAC_MSB-`ADCBS_DAC_LSB:0] dac_code_out,
  output logic hold_out,
  output logic [`ADCBS_MUX_MSB-`ADCBS_MUX_LSB:0] channel_mux_cells_out,
  output logic comparator_precharge_cell_out,
  output logic [`ADCBS_PORT_PINS-1:0] pe_pin_output_cell_out,
  output logic [`ADCBS_PORT_PINS-1:0] pe_pin_direction_cell_out,
  output logic [`ADCBS_PORT_PINS-1:0] pe_pin_pullup_cell_out,
  output logic [`ADCBS_PORT_PINS-1:0] pa_pin_output_cell_out,
  output logic [`ADCBS_PORT_PINS-1:0] pa_pin_direction_cell_out,
  output logic [`ADCBS_PORT_PINS-1:0] pa_pin_pullup_cell_out,
  output logic dummy_busy_out,
  output logic converter_ready_out
);
  localparam int LEN = `ADCBS_CHAIN_LEN;
  localparam int NP = `ADCBS_PORT_PINS;
  localparam int DW = `ADCBS_DAC_MSB - `ADCBS_DAC_LSB + 1;
  localparam int MW = `ADCBS_MUX_MSB - `ADCBS_MUX_LSB + 1;
  localparam int SETTLE_CYC = (`ADCBS_SETTLE_NS + `ADCBS_CLK_NS - 1) / `ADCBS_CLK_NS;

  // ****************************************
  // Pin synchronisers and TCK edges
  // ****************************************
  logic [2:0] pins_s;
  logic tck_s, tdi_s, comp_s;
  logic tck_prev_q, tck_prev_d;
  logic tck_rise, tck_fall;

  adcbs_sync2 #(.WIDTH(3)) u_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in({tck_in, tdi_in, comp_in}),
    .sync_out(pins_s)
  );
  assign tck_s = pins_s[2];
  assign tdi_s = pins_s[1];
  assign comp_s = pins_s[0];
  assign tck_prev_d = tck_s;
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ****************************************
  // Shift, capture and update stages
  // ****************************************
  logic [LEN-1:0] chain_q, chain_d;
  logic [LEN-1:0] upd_q, upd_d;
  logic tdo_q, tdo_d;

  always_comb begin
    chain_d = chain_q;
    upd_d = upd_q;
    tdo_d = tdo_q;
    if (tck_rise && capture_dr_in) begin
      chain_d = capture_vec_in;
      chain_d[`ADCBS_COMP_POS] = comp_s;
    end else if (tck_rise && shift_dr_in) begin
      // New bits enter at the top so the first one in ends at position 0
      chain_d = {tdi_s, chain_q[LEN-1:1]};
    end
    // TDO changes on the falling edge, giving the tester a full half period
    if (tck_fall && shift_dr_in) begin
      tdo_d = chain_q[0];
    end
    if (tck_fall && update_dr_in) begin
      upd_d = chain_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tck_prev_q <= 1'b0;
      chain_q <= '0;
      upd_q <= '0;
      tdo_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_prev_d;
      chain_q <= chain_d;
      upd_q <= upd_d;
      tdo_q <= tdo_d;
    end
  end
  assign tdo_out = tdo_q;

  // ****************************************
  // Pin cell mapping
  // ****************************************
  // Port F pins 4 to 7 own no positions; the TAP uses them
  logic [NP-1:0] pe_dat_w, pe_dir_w, pe_pu_w, pa_dat_w, pa_dir_w, pa_pu_w;
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      localparam int PE_POS = `ADCBS_PE_BASE - `ADCBS_CELLS_PER_PIN * gp;
      localparam int PA_POS = `ADCBS_PA_BASE - `ADCBS_CELLS_PER_PIN * (NP - 1 - gp);
      assign pe_dat_w[gp] = upd_q[PE_POS - int'(ADCBS_CELL_DATA)];
      assign pe_dir_w[gp] = upd_q[PE_POS - int'(ADCBS_CELL_DIR)];
      assign pe_pu_w[gp] = upd_q[PE_POS - int'(ADCBS_CELL_PULLUP)];
      assign pa_dat_w[gp] = upd_q[PA_POS - int'(ADCBS_CELL_DATA)];
      assign pa_dir_w[gp] = upd_q[PA_POS - int'(ADCBS_CELL_DIR)];
      assign pa_pu_w[gp] = upd_q[PA_POS - int'(ADCBS_CELL_PULLUP)];
    end
  endgenerate

  // ****************************************
  // Applied outputs
  // ****************************************
  logic conv_en_q, conv_en_d, hold_q, hold_d, comparator_precharge_cell_q, comparator_precharge_cell_d;
  logic [DW-1:0] dac_q, dac_d;
  logic [MW-1:0] mux_q, mux_d;
  logic [6*NP-1:0] pins_q, pins_d;

  always_comb begin
    if (extest_in) begin
      conv_en_d = upd_q[`ADCBS_CONV_EN_POS];
      dac_d = upd_q[`ADCBS_DAC_MSB:`ADCBS_DAC_LSB];
      hold_d = upd_q[`ADCBS_HOLD_POS];
      mux_d = upd_q[`ADCBS_MUX_MSB:`ADCBS_MUX_LSB];
      comparator_precharge_cell_d = upd_q[`ADCBS_COMPARATOR_PRECHARGE_CELL_POS];
      pins_d = {pe_dat_w, pe_dir_w, pe_pu_w, pa_dat_w, pa_dir_w, pa_pu_w};
    end else begin
      // Outside test the DAC, hold, mux and precharge sit at quiet values; enable follows func_conv_en_in
      conv_en_d = func_conv_en_in;
      dac_d = `ADCBS_DAC_MID;
      hold_d = `ADCBS_HOLD_SAFE;
      mux_d = `ADCBS_MUX_SAFE;
      comparator_precharge_cell_d = `ADCBS_COMPARATOR_PRECHARGE_CELL_SAFE;
      pins_d = '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conv_en_q <= 1'b0;
      dac_q <= `ADCBS_DAC_MID;
      hold_q <= `ADCBS_HOLD_SAFE;
      mux_q <= `ADCBS_MUX_SAFE;
      comparator_precharge_cell_q <= `ADCBS_COMPARATOR_PRECHARGE_CELL_SAFE;
      pins_q <= '0;
    end else begin
      conv_en_q <= conv_en_d;
      dac_q <= dac_d;
      hold_q <= hold_d;
      mux_q <= mux_d;
      comparator_precharge_cell_q <= comparator_precharge_cell_d;
      pins_q <= pins_d;
    end
  end
  assign converter_enable_cell_out = conv_en_q;
  assign dac_code_out = dac_q;
  assign hold_out = hold_q;
  assign channel_mux_cells_out = mux_q;
  assign comparator_precharge_cell_out = comparator_precharge_cell_q;
  assign {pe_pin_output_cell_out, pe_pin_direction_cell_out, pe_pin_pullup_cell_out,
          pa_pin_output_cell_out, pa_pin_direction_cell_out, pa_pin_pullup_cell_out} = pins_q;

  // ****************************************
  // Dummy conversion and settle timer
  // ****************************************
  adcbs_conv_state_t st_q, st_d;
  logic en_prev_q, en_prev_d;
  logic [1:0] step_q, step_d;
  logic [3:0] cmp_q, cmp_d;
  logic [5:0] settle_q, settle_d;
  logic conv_start;

  assign en_prev_d = conv_en_q;
  assign conv_start = conv_en_q & ~en_prev_q & ~extest_in;

  always_comb begin
    st_d = st_q;
    step_d = step_q;
    cmp_d = cmp_q;
    settle_d = settle_q;
    if (!conv_en_q) begin
      settle_d = '0;
    end else if (settle_q != 6'(SETTLE_CYC)) begin
      settle_d = settle_q + 6'h01;
    end
    unique case (st_q)
      ADCBS_IDLE: begin
        if (conv_start) begin
          st_d = ADCBS_CONV;
          step_d = '0;
          cmp_d = '0;
        end
      end
      ADCBS_CONV: begin
        // Step length is a fixed core-clock count, not the analog clock
        if (step_q == 2'(`ADCBS_STEP_CYC - 1)) begin
          step_d = '0;
          cmp_d = cmp_q + 4'h1;
          if (cmp_q == 4'(`ADCBS_CMP_STEPS - 1)) begin
            st_d = ADCBS_IDLE;
          end
        end else begin
          step_d = step_q + 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= ADCBS_IDLE;
      en_prev_q <= 1'b0;
      step_q <= '0;
      cmp_q <= '0;
      settle_q <= '0;
    end else begin
      st_q <= st_d;
      en_prev_q <= en_prev_d;
      step_q <= step_d;
      cmp_q <= cmp_d;
      settle_q <= settle_d;
    end
  end
  assign dummy_busy_out = (st_q == ADCBS_CONV);
  assign converter_ready_out = conv_en_q && (settle_q == 6'(SETTLE_CYC)) && !dummy_busy_out;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_update_edge;
    extest_in && tck_fall && update_dr_in;
  endsequence
  sequence s_applied;
    extest_in [*2];
  endsequence

  a_shift_lsb_first: assert property (tck_rise && shift_dr_in && !capture_dr_in |=>
      chain_q == {$past(tdi_s), $past(chain_q[LEN-1:1])})
    else $error("Shift did not move chain toward position 0");
  a_tdo_from_bit0: assert property (tck_fall && shift_dr_in |=> tdo_out == $past(chain_q[0]))
    else $error("TDO not taken from position 0");
  a_comp_capture: assert property (tck_rise && capture_dr_in |=>
      chain_q[193] == $past(comp_s))
    else $error("Comparator result not captured at position 193");
  a_update_applies: assert property (s_update_edge ##0 s_applied |=>
      dac_code_out == $past(chain_q[186:177], 2) && hold_out == $past(chain_q[174], 2)
      && comparator_precharge_cell_out == $past(chain_q[160], 2))
    else $error("Updated converter cells not applied");
  a_mux_enable_pos: assert property (s_update_edge ##0 s_applied |=>
      channel_mux_cells_out == $past(chain_q[172:165], 2)
      && converter_enable_cell_out == $past(chain_q[188], 2))
    else $error("Mux or enable cell at wrong position");
  a_pe_pin_cells: assert property (s_update_edge ##0 s_applied |=>
      pe_pin_output_cell_out[1] == $past(chain_q[154], 2)
      && pe_pin_direction_cell_out[1] == $past(chain_q[153], 2)
      && pe_pin_pullup_cell_out[1] == $past(chain_q[152], 2))
    else $error("Port E pin cells misplaced");
  a_pa_reversed: assert property (s_update_edge ##0 s_applied |=>
      pa_pin_output_cell_out[7] == $past(chain_q[23], 2)
      && pa_pin_output_cell_out[0] == $past(chain_q[2], 2))
    else $error("Port A cells not in reverse order");
  a_dummy_start: assert property (conv_start && st_q == ADCBS_IDLE |=> dummy_busy_out [*8])
    else $error("Dummy conversion did not start");
  a_dummy_ten: assert property ($fell(dummy_busy_out) |-> cmp_q == 4'(`ADCBS_CMP_STEPS))
    else $error("Dummy conversion not ten comparisons");
  a_dummy_length: assert property (conv_start && st_q == ADCBS_IDLE |=>
      dummy_busy_out [*8] ##[33:33] !dummy_busy_out)
    else $error("Dummy conversion wrong length");
endmodule : adcbs_chain

// >>> adcbs_tester.sv
// JTAG tester model: drives TCK, TDI, TAP levels and the analog comparator
`timescale 1ns/10ps
module adcbs_tester (
  input wire logic core_clk_in,
  input wire logic tdo_in,
  input wire logic [9:0] dac_code_in,
  output logic tck_out,
  output logic tdi_out,
  output logic capture_dr_out,
  output logic shift_dr_out,
  output logic update_dr_out,
  output logic comp_out
);
  // ****************************************
  // Tester
  // ****************************************
  initial begin
    {tck_out, tdi_out, capture_dr_out, shift_dr_out, update_dr_out} = 5'h00;
  end
  // Source sits between the two limits; comparator high once the code passes it
  always @(posedge core_clk_in) begin
    comp_out <= (dac_code_in > 10'h130);
  end
  // 12 high plus 13 low cycles give 125 ns, far above the hold-time bound
  task automatic tck_half(input logic lvl);
    tck_out <= lvl;
    repeat (lvl ? 12 : 13) @(posedge core_clk_in);
  endtask : tck_half
  // Capture, shift LSB first, update; TCK idles low between frames
  task automatic scan(input logic [197:0] din, output logic [197:0] dout);
    @(posedge core_clk_in);
    capture_dr_out <= 1'b1;
    tck_half(1'b1);
    capture_dr_out <= 1'b0;
    shift_dr_out <= 1'b1;
    tdi_out <= din[0];
    tck_half(1'b0);
    for (int i = 0; i < 198; i++) begin
      dout[i] = tdo_in;
      tck_half(1'b1);
      // Released data line shows the inverse, not a stale bit
      tdi_out <= (i < 197) ? din[i + 1] : ~din[i];
      tck_half(1'b0);
    end
    shift_dr_out <= 1'b0;
    update_dr_out <= 1'b1;
    tck_half(1'b1);
    tck_half(1'b0);
    update_dr_out <= 1'b0;
  endtask : scan
endmodule : adcbs_tester

// >>> adc_boundary_scan_chain_tb_top.sv
// Self-checking bench for the converter boundary-scan segment
`timescale 1ns/10ps
`include "adcbs_cfg.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module adc_boundary_scan_chain_tb_top;
  typedef struct packed {
    logic ext;
    logic [9:0] dac;
    logic hold;
    logic comparator_precharge_cell;
    logic [1:0] cmp;
  } adcbs_row_t;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic extest_in = 1'b0;
  logic func_conv_en_in = 1'b0;
  logic [197:0] capture_vec_in = {9{22'h2a_5c3f}};
  logic tck, tdi, comp, cap_dr, sh_dr, up_dr, tdo, en, hold, comparator_precharge_cell, busy, ready;
  logic [9:0] dac;
  logic [7:0] mux, pe_o, pe_d, pe_p, pa_o, pa_d, pa_p;
  logic [197:0] v, dout;
  int err_total = 0;
  int total_checks = 0;
  int n;
  // ****************************************
  // Table: instruction, DAC, hold, precharge, expected comparator (2 = none)
  // ****************************************
  adcbs_row_t rows [11] = '{'{0, 10'h200, 1, 1, 2}, '{1, 10'h200, 0, 1, 2},
    '{1, 10'h200, 1, 1, 2}, '{1, 10'h123, 1, 1, 2}, '{1, 10'h123, 1, 0, 2},
    '{1, 10'h200, 1, 1, 0}, '{1, 10'h200, 0, 1, 2}, '{1, 10'h200, 1, 1, 2},
    '{1, 10'h143, 1, 1, 2}, '{1, 10'h143, 1, 0, 2}, '{1, 10'h200, 1, 1, 1}};
  always #2.5 core_clk_in = ~core_clk_in;
  adcbs_chain dut_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .tck_in(tck),
    .tdi_in(tdi), .comp_in(comp), .capture_dr_in(cap_dr), .shift_dr_in(sh_dr),
    .update_dr_in(up_dr), .extest_in(extest_in), .func_conv_en_in(func_conv_en_in),
    .capture_vec_in(capture_vec_in), .tdo_out(tdo), .converter_enable_cell_out(en),
    .dac_code_out(dac), .hold_out(hold), .channel_mux_cells_out(mux),
    .comparator_precharge_cell_out(comparator_precharge_cell), .pe_pin_output_cell_out(pe_o),
    .pe_pin_direction_cell_out(pe_d), .pe_pin_pullup_cell_out(pe_p),
    .pa_pin_output_cell_out(pa_o), .pa_pin_direction_cell_out(pa_d),
    .pa_pin_pullup_cell_out(pa_p), .dummy_busy_out(busy), .converter_ready_out(ready));
  adcbs_tester tester_u (.core_clk_in(core_clk_in), .tdo_in(tdo), .dac_code_in(dac),
    .tck_out(tck), .tdi_out(tdi), .capture_dr_out(cap_dr), .shift_dr_out(sh_dr),
    .update_dr_out(up_dr), .comp_out(comp));
  // Pin cells stay 0: channel pin is an input with pull-up off
  function automatic logic [197:0] make_row(input logic [9:0] d, input logic h,
                                            input logic p);
    logic [197:0] r;
    r = '0;
    r[188] = 1'b1;
    r[186:177] = d;
    r[174] = h;
    r[172:165] = 8'h08;
    r[160] = p;
    return r;
  endfunction : make_row
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk_in);
    `CHK(dac, 10'h200)
    `CHK(({hold, comparator_precharge_cell, mux, busy}), 11'h602)
    resetn_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    for (int r = 0; r < 11; r++) begin
      extest_in <= rows[r].ext;
      // Converter just enabled by the instruction: let it settle first
      if (r == 1) repeat (40) @(posedge core_clk_in);
      tester_u.scan(make_row(rows[r].dac, rows[r].hold, rows[r].comparator_precharge_cell), dout);
      if (r == 0) `CHK(dout[157:0], capture_vec_in[157:0])
      if (rows[r].cmp != 2'h2) `CHK(dout[193], rows[r].cmp[0])
      `CHK(dac, (rows[r].ext ? rows[r].dac : 10'h200))
      `CHK(({hold, comparator_precharge_cell}), (rows[r].ext ? {rows[r].hold, rows[r].comparator_precharge_cell} : 2'h3))
      `CHK(mux, (rows[r].ext ? 8'h08 : 8'h01))
      `CHK(en, rows[r].ext)
      `CHK(busy, 1'b0)
    end
    // Distinct pin pattern with the converter off, so no pin contention
    v = make_row(10'h200, 1'b1, 1'b1);
    v[188] = 1'b0;
    v[157:0] = capture_vec_in[158:1];
    tester_u.scan(v, dout);
    for (int p = 0; p < 8; p++) begin
      `CHK(({pe_o[p], pe_d[p], pe_p[p]}), v[157 - 3 * p -: 3])
      `CHK(({pa_o[p], pa_d[p], pa_p[p]}), v[23 - 3 * (7 - p) -: 3])
    end
    extest_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    func_conv_en_in <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge core_clk_in);
      n++;
    end
    `CHK(ready, 1'b0)
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    `CHK(n, 40)
    repeat (3) @(negedge core_clk_in);
    `CHK(ready, 1'b1)
    // Mid-run reset with the converter on: all outputs but pe_d, pe_p and pa_o checked back at quiet values
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    @(posedge core_clk_in);
    `CHK(({tdo, en, busy, ready, pe_o, pa_d, pa_p}), 28'h000_0000)
    `CHK(({dac, hold, comparator_precharge_cell, mux}), 20'h8_0301)
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    // Enable still requested, so a fresh dummy conversion starts
    `CHK(({en, busy, ready}), 3'h6)
    complete_run();
  end
  // Twelve scans of about 25 us each; half as much again before giving up
  initial begin
    #450000;
    err_total++;
    $display("Watchdog expired before the sequence ended");
    complete_run();
  end
endmodule : adc_boundary_scan_chain_tb_top
